// ---- tb.sv ----
// Purpose: end-to-end bench, bus writes at one end, coil code at the other
// Assumes: device end built for address byte 0x18
// Notes:   each link transfer takes thousands of cycles
`timescale 1ns/1ns
`default_nettype none
module tb
	import vcmi_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        slp_n = 1'b1;
	logic        flt = 1'b0;
	logic        hsel = 1'b0;
	logic        hwr = 1'b0;
	logic [1:0]  htr = 2'h0;
	logic [31:0] ha = 32'h0;
	logic [31:0] hwd = 32'h0;
	logic [31:0] hrd, rd32;
	logic        hrdy, hrsp, en;
	logic [7:0]  code;
	int          num_errors = 0;
	int          n_checks = 0;
	// ****************
	// both ends
	// ****************
	vcmi_if lnk();
	vcmi_host u_vcmi_host (.I_CLK_SYS(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(ha),
		.I_HTRANS(htr), .I_HWRITE(hwr), .I_HSIZE(3'h2), .I_HREADY(hrdy), .I_HWDATA(hwd),
		.O_HRDATA(hrd), .O_HREADYOUT(hrdy), .O_HRESP(hrsp), .LINK(lnk.host));
	vcmi_dev #(.ADDR_SEL(2'h0)) u_vcmi_dev (.I_CLK_SYS(clk), .I_RST(rst),
		.I_SLEEP_N_INPUT(slp_n), .I_SUPPLY_FAULT(flt), .LINK(lnk.dev),
		.O_SINK_CURRENT_OUTPUT(code), .O_SINK_EN(en));
	vcmi_chk u_vcmi_chk (.I_CLK_SYS(clk), .I_RST(rst), .host_scl_o(lnk.host_scl_o),
		.host_scl_oe(lnk.host_scl_oe), .host_sda_o(lnk.host_sda_o),
		.host_sda_oe(lnk.host_sda_oe), .dev_sda_o(lnk.dev_sda_o),
		.dev_sda_oe(lnk.dev_sda_oe), .scl_line(lnk.scl_line), .sda_line(lnk.sda_line));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htr <= 2'h2;
		hwr <= w;
		ha <= {24'h0, a};
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htr <= 2'h0;
		hwd <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		rd32 = hrd;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		cmp($sformatf("register %h", a), e, rd32);
		cmp("read response", 32'h0, {31'h0, hrsp});
	endtask
	task automatic sink(input logic [8:0] e);
		cmp("enable and code", {23'h0, e}, {23'h0, en, code});
	endtask
	// busy polled until clear; a hang is left to the watchdog
	task automatic xfer(input logic [7:0] tgt, input logic [7:0] dat, input logic [2:0] cmd);
		bus(1'b1, REG_TGT, {24'h0, tgt});
		bus(1'b1, REG_DATA, {24'h0, dat});
		bus(1'b1, REG_CMD, {29'h0, cmd});
		rd32 = 32'h1;
		while (rd32[0] !== 1'b0) begin
			bus(1'b0, REG_STAT, 32'h0);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// tests need about 73k cycles
	initial begin
		#760000;
		num_errors++;
		tally_and_finish();
	end
	// ****************
	// tests
	// ****************
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		sink(9'h000);
		rreg(REG_STAT, 32'h0);
		rreg(8'h20, 32'h0);
		for (int i = 0; i < 4; i++) begin
			xfer(ADDR_BYTE_BASE + 8'(2 * i), 8'h81 + 8'(i), 3'h7);
			rreg(REG_STAT, (i == 0) ? 32'h0 : 32'h2);
			sink(9'h181);
		end
		rreg(REG_TGT, 32'h1E);
		rreg(REG_CMD, 32'h0);
		xfer(8'h18, 8'h3C, 3'h3);
		sink(9'h13C);
		xfer(8'h18, 8'hC3, 3'h2);
		sink(9'h1C3);
		xfer(8'h18, 8'h00, 3'h6);
		rreg(REG_STAT, 32'h0);
		sink(9'h000);
		xfer(8'h18, 8'h44, 3'h3);
		xfer(8'h18, 8'h55, 3'h3);
		rreg(REG_STAT, 32'h0);
		sink(9'h155);
		xfer(8'h19, 8'h00, 3'h1);
		rreg(REG_STAT, 32'h0);
		xfer(8'h19, 8'h00, 3'h6);
		rreg(REG_RX, 32'hFF);
		sink(9'h155);
		@(posedge clk);
		flt <= 1'b1;
		repeat (10) @(posedge clk);
		sink(9'h000);
		flt <= 1'b0;
		xfer(8'h18, 8'h77, 3'h7);
		sink(9'h177);
		slp_n <= 1'b0;
		repeat (10) @(posedge clk);
		sink(9'h000);
		xfer(8'h18, 8'h99, 3'h7);
		rreg(REG_STAT, 32'h2);
		slp_n <= 1'b1;
		repeat (10) @(posedge clk);
		sink(9'h000);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ---- vcmi_chk_sva.sv ----
// Purpose: link protocol checks between both ends
// Assumes: lines are open drain, resolved in the interface
// Notes:   bit count restarts at each start seen on the lines
`timescale 1ns/1ns
`default_nettype none
module vcmi_chk
	import vcmi_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl_line,
	input wire logic sda_line
);
	// ****************
	// bit position
	// ****************
	logic       scl_d, sda_d, first, rd_dir, rise, strt;
	logic [3:0] nbit;
	logic [6:0] gap;
	assign rise = scl_line & ~scl_d;
	assign strt = scl_line & scl_d & sda_d & ~sda_line;
	always_ff @(posedge I_CLK_SYS) begin
		scl_d <= I_RST | scl_line;
		sda_d <= I_RST | sda_line;
		gap <= (I_RST | (scl_line != scl_d)) ? 7'h00 : gap + {6'h00, ~&gap};
		rd_dir <= I_RST ? 1'b0 : (rise & first & (nbit == 4'h7)) ? sda_line : rd_dir;
		if (I_RST | strt) begin
			nbit <= 4'h0;
			first <= 1'b1;
		end else if (rise) begin
			nbit <= (nbit == ACK_SLOT) ? 4'h0 : nbit + 4'h1;
			first <= first & (nbit != ACK_SLOT);
		end
	end
	// ****************
	// checks
	// ****************
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_RST);
	chk_dev_low_only: assert property (dev_sda_oe |-> !dev_sda_o)
		else $error("device drives data high");
	chk_host_low_only: assert property ((host_sda_oe | host_scl_oe) |-> !(host_sda_o | host_scl_o))
		else $error("master drives a line high");
	chk_clk_quarter: assert property ((scl_line != scl_d) |-> gap >= QTR_LAST)
		else $error("clock edges too close");
	chk_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl_line)
		else $error("device moved data while clock high");
	chk_ack_slot_only: assert property ((rise & dev_sda_oe) |-> nbit == ACK_SLOT)
		else $error("device drove data outside ack slot");
	chk_ack_release: assert property ((dev_sda_oe & scl_d & ~scl_line) |-> ##[2:6] !dev_sda_oe)
		else $error("ack not released after ninth clock");
	chk_ack_held: assert property ($rose(dev_sda_oe) |-> dev_sda_oe throughout (##[1:250] rise))
		else $error("ack dropped before ninth clock high");
	chk_master_frees: assert property ((rise & (nbit == ACK_SLOT)) |-> !host_sda_oe)
		else $error("master holds data in ack slot");
	chk_read_quiet: assert property ($rose(dev_sda_oe) |-> !(rd_dir & ~first))
		else $error("device drove data in a read");
	chk_data_steady: assert property (rise |-> $stable(host_sda_oe) [*8])
		else $error("data changed just after clock rise");
endmodule
`default_nettype wire

// ---- vcmi_dev.sv ----
// Purpose: coil driver end, write-only serial slave with current code
// Assumes: link clock sampled by I_CLK_SYS, far slower than it
// Notes:   reset stands for power-up; fault input for supply fault
//
// Notes on behaviour
// R01 - master alone drives the clock line
// R02 - data line is input or low-only drive
// R03 - data falling while clock high starts
// R04 - data rising while clock high stops
// R05 - seven address bits, direction bit, ack slot
// R06 - direction low writes, high reads
// R07 - address byte 0x18, 0x1A, 0x1C or 0x1E
// R08 - address choice is a build parameter
// R09 - matching address acked low through ninth clock
// R10 - each written byte loads the code register
// R11 - bit 0 is code lsb, bit 7 msb
// R12 - each data byte acknowledged in next period
// R13 - master releases data before ninth clock
// R14 - many data bytes per transfer until stop
// R15 - master changes data only while clock low
// R16 - start or stop aborts and restarts sequencing
// R17 - no readback of any internal state
// R18 - read transfer leaves data released after address
// R19 - code presented unchanged, 500 uA per step
// R20 - code zero disables sink drive
// R21 - code cleared at power-up and supply fault
// R22 - sleep low disables all circuitry and output
// R23 - asleep ignores bus, code zero on wake
`timescale 1ns/1ns
`default_nettype none
module vcmi_dev
	import vcmi_pkg::*;
#(
	parameter logic [1:0] ADDR_SEL = 2'h0
) (
	input  wire logic  I_CLK_SYS,
	input  wire logic  I_RST,
	input  wire logic  I_SLEEP_N_INPUT,
	input  wire logic  I_SUPPLY_FAULT,
	vcmi_if.dev        LINK,
	output logic [7:0] O_SINK_CURRENT_OUTPUT,
	output logic       O_SINK_EN
);
	// ****************************
	// input sampling
	// ****************************
	localparam logic [6:0] DEV_ADDR = vcmi_dev_addr(ADDR_SEL); // R07 R08

	logic [3:0] sync_q;
	logic       scl_s;
	logic       sda_s;
	logic       awake;
	logic       fault;
	logic       scl_p;
	logic       sda_p;

	// link clock is only sampled, never driven
	vcmi_sync #(
		.W    (4),
		.INIT (4'h7)
	) u_sync (
		.i_clk (I_CLK_SYS),
		.i_rst (I_RST),
		.i_d   ({I_SUPPLY_FAULT, I_SLEEP_N_INPUT, LINK.sda_line, LINK.scl_line}),
		.o_q   (sync_q)
	); // R01

	assign scl_s = sync_q[0];
	assign sda_s = sync_q[1];
	assign awake = sync_q[2];
	assign fault = sync_q[3];

	// ****************************
	// line events
	// ****************************
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;

	// both lines judged on synced copies only, so pin skew cannot fake a start;
	// the master keeps its data a quarter bit away from its clock edges
	assign start_det = scl_s & scl_p & sda_p & ~sda_s; // R03
	assign stop_det  = scl_s & scl_p & ~sda_p & sda_s; // R04
	assign scl_rise  = scl_s & ~scl_p;
	assign scl_fall  = ~scl_s & scl_p;

	// previous copies reset to the idle high level: no false edge after reset
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_p <= scl_s;
			sda_p <= sda_s;
		end
	end

	// ****************************
	// byte sequencing
	// ****************************
	vcmi_dst_e  state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic       sda_oe;
	logic       byte_full;
	logic       addr_hit;
	logic       wr_dir;
	logic       seq_run;
	logic       shift_en;
	logic       load_code;

	// count stops at a full byte, so the ninth clock never shifts
	// address match ignores the direction bit: a read is acked, then left alone
	assign byte_full = bit_cnt == BYTE_BITS; // R05
	assign addr_hit  = shreg[7:1] == DEV_ADDR; // R09
	assign wr_dir    = ~shreg[0]; // R06
	assign seq_run   = awake & ~start_det & ~stop_det;
	assign shift_en  = scl_rise & ~byte_full & (state == D_ADDR || state == D_DATA);
	assign load_code = seq_run & (state == D_DATA) & scl_fall & byte_full; // R10 R14

	// releasing on the falling edge keeps the ack low for the whole ninth high phase
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			state   <= D_IDLE;
			bit_cnt <= 4'h0;
			shreg   <= 8'h00;
			sda_oe  <= 1'b0;
		end else if (!awake) begin
			state  <= D_IDLE; // R22 R23
			sda_oe <= 1'b0;
		end else if (start_det) begin
			state   <= D_ADDR; // R03 R16
			bit_cnt <= 4'h0;
			sda_oe  <= 1'b0;
		end else if (stop_det) begin
			state  <= D_IDLE; // R04 R16
			sda_oe <= 1'b0;
		end else begin
			if (shift_en) begin
				shreg   <= {shreg[6:0], sda_s}; // R11
				bit_cnt <= bit_cnt + 4'h1;
			end
			case (state)
				D_ADDR: begin
					if (scl_fall && byte_full) begin
						sda_oe <= addr_hit; // R09
						state  <= addr_hit ? D_ACKA : D_SKIP;
					end
				end
				D_ACKA: begin
					if (scl_fall) begin
						sda_oe  <= 1'b0;
						bit_cnt <= 4'h0;
						state   <= wr_dir ? D_DATA : D_SKIP; // R18
					end
				end
				D_DATA: begin
					if (scl_fall && byte_full) begin
						sda_oe <= 1'b1; // R12
						state  <= D_ACKD;
					end
				end
				D_ACKD: begin
					if (scl_fall) begin
						sda_oe  <= 1'b0;
						bit_cnt <= 4'h0;
						state   <= D_DATA; // R14
					end
				end
				default: begin
					// wrong address or read: off the line until a start or stop
					sda_oe <= 1'b0; // R17
				end
			endcase
		end
	end

	// pin value tied low; only the enable moves, so the line is never driven high
	assign LINK.dev_sda_o  = 1'b0; // R02
	assign LINK.dev_sda_oe = sda_oe; // R02

	// ****************************
	// current code register
	// ****************************
	logic [7:0] code;
	logic [7:0] next_code;
	logic       sink_en;

	// fault and sleep beat a load in the same cycle; code stays zero while either stands
	assign next_code = (fault || !awake) ? CODE_RST : (load_code ? shreg : code); // R21 R23

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			code    <= CODE_RST; // R21
			sink_en <= 1'b0;
		end else begin
			code    <= next_code; // R10
			sink_en <= |next_code; // R20 R22
		end
	end

	// converter scales the code by one step per unit; nothing analog modelled here
	assign O_SINK_CURRENT_OUTPUT = code; // R19
	assign O_SINK_EN             = sink_en;
endmodule
`default_nettype wire

// ---- vcmi_host.sv ----
// Purpose: bus master end, AHB-Lite registers driving the two-wire link
// Assumes: single-word AHB transfers, zero wait states
// Notes:   no clock stretching support; device never stretches
`timescale 1ns/1ns
`default_nettype none
module vcmi_host
	import vcmi_pkg::*;
(
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_RST,
	input  wire logic        I_HSEL,
	input  wire logic [31:0] I_HADDR,
	input  wire logic [1:0]  I_HTRANS,
	input  wire logic        I_HWRITE,
	input  wire logic [2:0]  I_HSIZE,
	input  wire logic        I_HREADY,
	input  wire logic [31:0] I_HWDATA,
	output logic      [31:0] O_HRDATA,
	output logic             O_HREADYOUT,
	output logic             O_HRESP,
	vcmi_if.host             LINK
);
	// ****************************
	// bus slave
	// ****************************
	vcmi_hst_e  state;
	logic [2:0] pend;
	logic [7:0] tgt;
	logic [7:0] txd;
	logic [7:0] rxd;
	logic       nack;
	logic       busy;
	logic       ap_wr;
	logic [7:0] ap_addr;
	logic       ap_take;
	logic       wr_tgt;
	logic       wr_data;
	logic       wr_cmd;
	logic [31:0] rd_val;

	assign busy    = (state != H_IDLE) | (|pend);
	assign ap_take = I_HSEL & I_HTRANS[HTRANS_ACT] & I_HREADY;
	assign wr_tgt  = ap_wr & vcmi_hit(ap_addr, REG_TGT);
	assign wr_data = ap_wr & vcmi_hit(ap_addr, REG_DATA);
	// commands while busy are dropped so a sequence is never torn
	assign wr_cmd  = ap_wr & vcmi_hit(ap_addr, REG_CMD) & ~busy;
	assign rd_val  = vcmi_hit(I_HADDR[7:0], REG_TGT)  ? {24'h000000, tgt} :
	                 vcmi_hit(I_HADDR[7:0], REG_DATA) ? {24'h000000, txd} :
	                 vcmi_hit(I_HADDR[7:0], REG_STAT) ? {30'h0, nack, busy} :
	                 vcmi_hit(I_HADDR[7:0], REG_RX)   ? {24'h000000, rxd} : 32'h00000000;

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			ap_wr       <= 1'b0;
			ap_addr     <= 8'h00;
			O_HRDATA    <= 32'h00000000;
			O_HREADYOUT <= 1'b1;
			O_HRESP     <= 1'b0;
		end else begin
			ap_wr   <= ap_take & I_HWRITE;
			ap_addr <= I_HADDR[7:0];
			if (ap_take && !I_HWRITE) begin
				O_HRDATA <= rd_val;
			end
		end
	end

	// ****************************
	// quarter-bit divider
	// ****************************
	logic [6:0] div;
	logic       tick;
	logic       sda_in;

	assign tick = div == QTR_LAST;

	vcmi_sync #(
		.W    (1),
		.INIT (1'b1)
	) u_sync (
		.i_clk (I_CLK_SYS),
		.i_rst (I_RST),
		.i_d   (LINK.sda_line),
		.o_q   (sda_in)
	);

	// ****************************
	// bit engine
	// ****************************
	logic [1:0] q;
	logic [3:0] bit_cnt;
	logic [7:0] sh;
	logic       addr_ph;
	logic       rd_mode;
	logic       scl_oe;
	logic       sda_oe;
	logic       tx_bit;
	logic       ack_slot;

	assign ack_slot = bit_cnt == ACK_SLOT;
	assign tx_bit   = ack_slot | (rd_mode & ~addr_ph) | sh[7]; // R13 R05

	// master changes data bits only in the low phase q0; start and stop move data in q2 with the clock high
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			div     <= 7'h00;
			state   <= H_IDLE;
			pend    <= 3'h0;
			q       <= 2'h0;
			tgt     <= 8'h00;
			txd     <= 8'h00;
			rxd     <= 8'h00;
			nack    <= 1'b0;
			bit_cnt <= 4'h0;
			sh      <= 8'h00;
			addr_ph <= 1'b0;
			rd_mode <= 1'b0;
			scl_oe  <= 1'b0;
			sda_oe  <= 1'b0;
		end else begin
			div <= tick ? 7'h00 : div + 7'h01;
			if (wr_tgt) begin
				tgt <= I_HWDATA[7:0];
			end
			if (wr_data) begin
				txd <= I_HWDATA[7:0];
			end
			if (wr_cmd) begin
				pend <= I_HWDATA[2:0];
				nack <= 1'b0;
			end else if (tick) begin
				case (state)
					H_IDLE: begin
						q <= 2'h0;
						if (pend[CMD_START]) begin
							pend[CMD_START] <= 1'b0;
							state <= H_START;
						end else if (pend[CMD_BYTE]) begin
							pend[CMD_BYTE] <= 1'b0;
							sh      <= txd;
							addr_ph <= 1'b0;
							bit_cnt <= 4'h0;
							state <= H_BIT;
						end else if (pend[CMD_STOP]) begin
							pend[CMD_STOP] <= 1'b0;
							state <= H_STOP;
						end
					end
					H_START: begin
						q <= q + 2'h1;
						case (q)
							2'h0: sda_oe <= 1'b0;
							2'h1: scl_oe <= 1'b0;
							2'h2: sda_oe <= 1'b1; // R03
							default: begin
								scl_oe  <= 1'b1;
								sh      <= tgt;
								rd_mode <= tgt[0];
								addr_ph <= 1'b1;
								bit_cnt <= 4'h0;
								state   <= H_BIT;
							end
						endcase
					end
					H_BIT: begin
						q <= q + 2'h1;
						case (q)
							2'h0: sda_oe <= ~tx_bit; // R15
							2'h1: scl_oe <= 1'b0; // R01
							2'h2: begin
								if (!ack_slot) begin
									sh <= {sh[6:0], sda_in};
								end else if (addr_ph || !rd_mode) begin
									nack <= sda_in;
								end
							end
							default: begin
								scl_oe <= 1'b1;
								if (ack_slot) begin
									state <= H_IDLE;
									if (!addr_ph && rd_mode) begin
										rxd <= sh;
									end
								end else begin
									bit_cnt <= bit_cnt + 4'h1;
								end
							end
						endcase
					end
					default: begin
						q <= q + 2'h1;
						case (q)
							2'h0: sda_oe <= 1'b1;
							2'h1: scl_oe <= 1'b0;
							2'h2: sda_oe <= 1'b0; // R04
							default: state <= H_IDLE;
						endcase
					end
				endcase
			end
		end
	end

	assign LINK.host_scl_o  = 1'b0;
	assign LINK.host_scl_oe = scl_oe;
	assign LINK.host_sda_o  = 1'b0;
	assign LINK.host_sda_oe = sda_oe;
endmodule
`default_nettype wire

// ---- vcmi_if.sv ----
// Purpose: two-wire link between bus master end and coil driver end
// Assumes: both lines pulled up; every driver is open drain
// Notes:   resolved levels computed here from the enables
`timescale 1ns/1ns
`default_nettype none
interface vcmi_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl_line;
	logic sda_line;
	assign scl_line = ~(host_scl_oe & ~host_scl_o);
	assign sda_line = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	modport host (
		output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
		input  scl_line, sda_line
	);
	modport dev (
		output dev_sda_o, dev_sda_oe,
		input  scl_line, sda_line
	);
endinterface
`default_nettype wire

// ---- vcmi_pkg.sv ----
// Purpose: shared constants for the coil current link, both ends
// Assumes: 125 MHz system clock on both ends
// Notes:   host register map is local to the bus master end
`default_nettype none
package vcmi_pkg;
	// ****************************
	// timing
	// ****************************
	localparam int         CLK_NS   = 8;
	localparam int         QTR_NS   = 650;
	localparam int         QTR_CYC  = (QTR_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);
	// ****************************
	// link framing
	// ****************************
	localparam logic [7:0] ADDR_BYTE_BASE = 8'h18;
	localparam logic [3:0] BYTE_BITS      = 4'h8;
	localparam logic [3:0] ACK_SLOT       = 4'h8;
	localparam logic [7:0] CODE_RST       = 8'h00;
	// ****************************
	// host registers
	// ****************************
	localparam logic [7:0] REG_TGT  = 8'h00;
	localparam logic [7:0] REG_DATA = 8'h04;
	localparam logic [7:0] REG_CMD  = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_RX   = 8'h10;
	localparam int         CMD_START = 0;
	localparam int         CMD_BYTE  = 1;
	localparam int         CMD_STOP  = 2;
	localparam int         HTRANS_ACT = 1;
	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_ADDR = 3'h1,
		D_ACKA = 3'h3,
		D_DATA = 3'h2,
		D_ACKD = 3'h6,
		D_SKIP = 3'h4
	} vcmi_dst_e;
	typedef enum logic [1:0] {
		H_IDLE  = 2'h0,
		H_START = 2'h1,
		H_BIT   = 2'h3,
		H_STOP  = 2'h2
	} vcmi_hst_e;
	function automatic logic [6:0] vcmi_dev_addr(input logic [1:0] sel);
		return 7'(ADDR_BYTE_BASE[7:1] + {5'h00, sel});
	endfunction
	function automatic logic vcmi_hit(input logic [7:0] a, input logic [7:0] ofs);
		return a[7:2] == ofs[7:2];
	endfunction
endpackage
`default_nettype wire

// ---- vcmi_sync.sv ----
// Purpose: two-flop synchroniser for levels from outside the clock
// Assumes: inputs are slow levels
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ns
`default_nettype none
module vcmi_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta <= INIT;
			o_q  <= INIT;
		end else begin
			meta <= i_d;
			o_q  <= meta;
		end
	end
endmodule
`default_nettype wire
